// *** design/bert_defs.vh ***
// register map, field positions, reset values and counts of the bit error rate tester
`ifndef BERT_DEFS_VH
`define BERT_DEFS_VH

`define BERT_ADDR_W         8
`define BERT_TOP_CTL_OFS    8'h00
`define BERT_CTL_OFS        8'h04
`define BERT_CFG_OFS        8'h08
`define BERT_SEED_OFS       8'h0c
`define BERT_LIVE_OFS       8'h10
`define BERT_LAT_OFS        8'h14
`define BERT_IEN_OFS        8'h18
`define BERT_GIC_OFS        8'h1c
`define BERT_BITCNT_OFS     8'h20
`define BERT_ERRCNT_OFS     8'h24

// tester_top_control
`define BERT_TOP_EN         0
// tester_control
`define BERT_CTL_TXLD       0
`define BERT_CTL_RXLD       1
`define BERT_CTL_PMU        2
`define BERT_CTL_SEI        3
`define BERT_CTL_SRC        4
`define BERT_CTL_INV        5
`define BERT_CTL_ARDIS      6
`define BERT_CTL_RATE_LO    8
`define BERT_CTL_RATE_HI    10
// pattern configuration
`define BERT_CFG_LEN_LO     0
`define BERT_CFG_LEN_HI     4
`define BERT_CFG_TAP_LO     8
`define BERT_CFG_TAP_HI     12
`define BERT_CFG_REP        16
`define BERT_CFG_QRSS       17
// event bit positions, shared by live, latched and enable registers
`define BERT_EV_PMU         0
`define BERT_EV_BE          1
`define BERT_EV_BEC         2
`define BERT_EV_OOS         3
// global_irq_control
`define BERT_GIC_CWE        0

`define BERT_CFG_RST        32'h0000_0000
`define BERT_SEED_RST       32'h0000_0000
`define BERT_EV_RST         4'h0

`define BERT_LOAD_BITS      6'd32
`define BERT_VERIFY_LAST    6'd31
`define BERT_WIN_LAST       6'd63
`define BERT_RESYNC_ERRS    4'd6
`define BERT_ERR_MAX        4'd15

`endif

// *** design/bert_erate.v ***
// decade error rate generator: one pulse every 10^n advanced bits
`timescale 1ns/100ps
module bert_erate (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       clr_i,
   input  wire       adv_i,
   input  wire [2:0] rate_i,
   output wire       err_o
);
   reg [23:0] cnt;
   reg [23:0] last;

   always @* begin
      case (rate_i)
         3'd1:    last = 24'd9;
         3'd2:    last = 24'd99;
         3'd3:    last = 24'd999;
         3'd4:    last = 24'd9999;
         3'd5:    last = 24'd99999;
         3'd6:    last = 24'd999999;
         3'd7:    last = 24'd9999999;
         default: last = 24'd0;
      endcase
   end

   // rate zero switches insertion off
   assign err_o = adv_i && (rate_i != 3'd0) && (cnt == last);

   always @(posedge clk_i) begin
      if (rst_i || clr_i || (rate_i == 3'd0))
         cnt <= 24'd0;
      else if (adv_i)
         cnt <= (cnt >= last) ? 24'd0 : cnt + 24'd1;
   end
endmodule // bert_erate

// *** design/bert_pgen.v ***
// 32-bit pattern generator shared by the transmit and receive paths
`timescale 1ns/100ps
module bert_pgen (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        load_i,
   input  wire [31:0] seed_i,
   input  wire        adv_i,
   input  wire        ext_sel_i,
   input  wire        ext_i,
   input  wire [4:0]  len_i,
   input  wire [4:0]  tap_i,
   input  wire        rep_i,
   input  wire        qrss_i,
   output wire        out_o,
   output wire [31:0] state_o
);
   reg  [31:0] sr;
   reg         fb;
   // len_i holds n-1, so this leaves n ones in the low bits
   wire [31:0] mask = 32'hffff_ffff >> (5'd31 - len_i);

   always @* begin
      if (qrss_i)
         fb = sr[16] ^ sr[19];
      else if (rep_i)
         fb = sr[len_i];
      else
         fb = sr[len_i] ^ sr[tap_i];
      // an all-zero register would never leave zero
      if (!rep_i && (sr[30:0] == 31'h0000_0000))
         fb = 1'b1;
   end

   // qrss limits runs of zeros to fourteen
   assign out_o   = fb | (qrss_i & (sr[13:0] == 14'h0000));
   assign state_o = sr;

   always @(posedge clk_i) begin
      if (rst_i)
         sr <= 32'h0000_0000;
      else if (load_i)
         sr <= seed_i & mask;
      else if (adv_i)
         sr <= {sr[30:0], ext_sel_i ? ext_i : fb};
   end
endmodule // bert_pgen

// *** design/bert_top.v ***
// bit error rate tester: pattern generation, receive sync, counters, apb registers
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
`include "bert_defs.vh"
module bert_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   input  wire        tx_bit_req_i,
   output reg         tx_data_o,
   output reg         tx_valid_o,
   input  wire        rx_data_i,
   input  wire        rx_valid_i,
   input  wire        manual_error_insert_in_i,
   output reg         out_of_sync_o,
   output reg         irq_n_o
);
   localparam ST_SRCH   = 2'd0;
   localparam ST_VERIFY = 2'd1;
   localparam ST_SYNC   = 2'd2;

   // registers
   reg         tester_enable;
   reg         tx_pattern_load;
   reg         rx_pattern_load;
   reg         perf_update_trigger;
   reg         err_src_pin;
   reg         tx_invert;
   reg         auto_resync_dis;
   reg  [2:0]  err_rate;
   reg  [31:0] pattern_cfg;
   reg  [31:0] seed;
   reg  [3:0]  tester_latched_events;
   reg  [3:0]  tester_event_enables;
   reg         clear_by_write_select;
   reg         perf_update_status;
   reg  [31:0] bit_count_rd;
   reg  [23:0] error_count_rd;

   // engine state
   reg  [1:0]  st;
   reg  [5:0]  cnt;
   reg  [5:0]  vcnt;
   reg  [5:0]  win;
   reg  [3:0]  errs;
   reg  [31:0] bit_cnt;
   reg  [23:0] err_cnt;
   reg         single_pend;
   reg         pin_q;
   reg         oos_q;
   reg         nz_q;
   reg  [31:0] rdata;
   reg         rd_ok;
   reg  [3:0]  next_lat;
   reg  [3:0]  lat_clr;
   reg  [1:0]  next_st;

   wire [4:0]  plen = pattern_cfg[`BERT_CFG_LEN_HI:`BERT_CFG_LEN_LO];
   wire [4:0]  ptap = pattern_cfg[`BERT_CFG_TAP_HI:`BERT_CFG_TAP_LO];
   wire        prep = pattern_cfg[`BERT_CFG_REP];
   wire        pqrss = pattern_cfg[`BERT_CFG_QRSS];
   wire [31:0] pmask = 32'hffff_ffff >> (5'd31 - plen);

   // apb: zero wait is not offered; pready rises one cycle into access
   wire acc  = psel_i & penable_i & pready_o;
   wire wr   = acc & pwrite_i;
   wire rd   = acc & ~pwrite_i;
   wire wr_ctl = wr && (paddr_i == `BERT_CTL_OFS);

   // rising-edge writes of the load and update bits
   wire tx_load_go = wr_ctl & pwdata_i[`BERT_CTL_TXLD] & ~tx_pattern_load;
   wire rx_load_go = wr_ctl & pwdata_i[`BERT_CTL_RXLD] & ~rx_pattern_load;
   wire pmu_go     = wr_ctl & pwdata_i[`BERT_CTL_PMU] & ~perf_update_trigger;

   // transmit side
   wire tx_adv = tester_enable & tx_bit_req_i;
   wire tx_pat;
   wire rate_err;
   wire reg_sei = wr_ctl & pwdata_i[`BERT_CTL_SEI];
   wire pin_sei = manual_error_insert_in_i & ~pin_q;
   wire sei_go  = err_src_pin ? pin_sei : reg_sei;
   wire ins_err = rate_err | single_pend;

   bert_pgen u_tx_gen (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (tx_load_go),
      .seed_i    (seed),
      .adv_i     (tx_adv),
      .ext_sel_i (1'b0),
      .ext_i     (1'b0),
      .len_i     (plen),
      .tap_i     (ptap),
      .rep_i     (prep),
      .qrss_i    (pqrss),
      .out_o     (tx_pat),
      .state_o   ()
   );

   bert_erate u_rate (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .clr_i  (tx_load_go),
      .adv_i  (tx_adv),
      .rate_i (err_rate),
      .err_o  (rate_err)
   );

   // receive side
   wire        rx_bit = tester_enable & rx_valid_i;
   wire        rx_pat;
   wire [31:0] rx_state;
   wire        rep_match = (rx_state & pmask) == (seed & pmask);
   wire        srch_done = prep ? ((cnt > {1'b0, plen}) && rep_match)
                                : (cnt == `BERT_LOAD_BITS);
   wire        checking  = (st != ST_SRCH) | srch_done;
   wire        miss      = rx_bit & checking & (rx_pat != rx_data_i);
   wire        in_sync   = (st == ST_SYNC);
   wire [3:0]  errs_sum  = ((win == 6'd0) ? 4'd0 : errs) + {3'd0, miss};
   wire        count_en  = rx_bit & in_sync;

   bert_pgen u_rx_gen (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .load_i    (1'b0),
      .seed_i    (32'h0000_0000),
      .adv_i     (rx_bit),
      .ext_sel_i (~checking),
      .ext_i     (rx_data_i),
      .len_i     (plen),
      .tap_i     (ptap),
      .rep_i     (prep),
      .qrss_i    (pqrss),
      .out_o     (rx_pat),
      .state_o   (rx_state)
   );

   // sync state machine
   always @* begin
      next_st = st;
      case (st)
         ST_SRCH: begin
            if (rx_bit && srch_done)
               next_st = miss ? ST_SRCH : ST_VERIFY;
         end
         ST_VERIFY: begin
            if (miss)
               next_st = ST_SRCH;
            else if (rx_bit && (vcnt == `BERT_VERIFY_LAST))
               next_st = ST_SYNC;
         end
         ST_SYNC: begin
            if (rx_bit && (errs_sum >= `BERT_RESYNC_ERRS) && !auto_resync_dis)
               next_st = ST_SRCH;
         end
         default: next_st = ST_SRCH;
      endcase
      if (!tester_enable || rx_load_go)
         next_st = ST_SRCH;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         st   <= ST_SRCH;
         cnt  <= 6'd0;
         vcnt <= 6'd0;
         win  <= 6'd0;
         errs <= 4'd0;
      end else begin
         st <= next_st;
         if (next_st == ST_SRCH) begin
            vcnt <= 6'd0;
            if (st != ST_SRCH || rx_load_go || miss)
               cnt <= 6'd0;
            else if (rx_bit && !srch_done && cnt != 6'h3f)
               cnt <= cnt + 6'd1;
         end else if (next_st == ST_VERIFY) begin
            if (rx_bit)
               vcnt <= vcnt + 6'd1;
            win  <= 6'd0;
            errs <= 4'd0;
         end else if (rx_bit && in_sync) begin
            // the window restarts every 64 bits
            win  <= (win == `BERT_WIN_LAST) ? 6'd0 : win + 6'd1;
            errs <= (errs_sum > `BERT_ERR_MAX - 4'd1) ? `BERT_ERR_MAX : errs_sum;
         end
      end
   end

   // event detection and latched status
   wire oos_now = (st != ST_SYNC);
   wire nz_now  = (err_cnt != 24'd0);
   wire [3:0] ev;
   assign ev[`BERT_EV_PMU] = pmu_go;
   assign ev[`BERT_EV_BE]  = count_en & miss;
   assign ev[`BERT_EV_BEC] = nz_now & ~nz_q;
   assign ev[`BERT_EV_OOS] = oos_now ^ oos_q;

   always @* begin
      lat_clr = 4'h0;
      if (rd && (paddr_i == `BERT_LAT_OFS) && !clear_by_write_select)
         lat_clr = 4'hf;
      else if (wr && (paddr_i == `BERT_LAT_OFS) && clear_by_write_select)
         lat_clr = pwdata_i[3:0];
      // a new event in the clearing cycle survives
      next_lat = (tester_latched_events & ~lat_clr) | ev;
   end

   // counters, snapshots, transmit output
   always @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt        <= 32'd0;
         err_cnt        <= 24'd0;
         bit_count_rd   <= 32'd0;
         error_count_rd <= 24'd0;
         tester_latched_events <= `BERT_EV_RST;
         oos_q          <= 1'b1;
         nz_q           <= 1'b0;
         pin_q          <= 1'b0;
         single_pend    <= 1'b0;
         tx_data_o      <= 1'b0;
         tx_valid_o     <= 1'b0;
         out_of_sync_o  <= 1'b1;
         irq_n_o        <= 1'b1;
      end else begin
         if (pmu_go) begin
            bit_count_rd   <= bit_cnt;
            error_count_rd <= err_cnt;
            bit_cnt <= {31'd0, count_en};
            err_cnt <= {23'd0, count_en & miss};
         end else if (count_en) begin
            bit_cnt <= bit_cnt + 32'd1;
            if (miss)
               err_cnt <= err_cnt + 24'd1;
         end
         tester_latched_events <= next_lat;
         oos_q         <= oos_now;
         nz_q          <= nz_now;
         pin_q         <= manual_error_insert_in_i;
         // one pending single error, spent on the next outgoing bit
         single_pend   <= sei_go | (single_pend & ~tx_adv);
         tx_valid_o    <= tx_adv;
         if (tx_adv)
            tx_data_o  <= tx_pat ^ tx_invert ^ ins_err;
         out_of_sync_o <= oos_now;
         irq_n_o       <= ~|(next_lat & tester_event_enables);
      end
   end

   // register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         tester_enable         <= 1'b0;
         tx_pattern_load       <= 1'b0;
         rx_pattern_load       <= 1'b0;
         perf_update_trigger   <= 1'b0;
         err_src_pin           <= 1'b0;
         tx_invert             <= 1'b0;
         auto_resync_dis       <= 1'b0;
         err_rate              <= 3'd0;
         pattern_cfg           <= `BERT_CFG_RST;
         seed                  <= `BERT_SEED_RST;
         tester_event_enables  <= `BERT_EV_RST;
         clear_by_write_select <= 1'b0;
         perf_update_status    <= 1'b0;
      end else begin
         if (wr && paddr_i == `BERT_TOP_CTL_OFS)
            tester_enable <= pwdata_i[`BERT_TOP_EN];
         if (wr_ctl) begin
            tx_pattern_load     <= pwdata_i[`BERT_CTL_TXLD];
            rx_pattern_load     <= pwdata_i[`BERT_CTL_RXLD];
            perf_update_trigger <= pwdata_i[`BERT_CTL_PMU];
            err_src_pin         <= pwdata_i[`BERT_CTL_SRC];
            tx_invert           <= pwdata_i[`BERT_CTL_INV];
            auto_resync_dis     <= pwdata_i[`BERT_CTL_ARDIS];
            err_rate            <= pwdata_i[`BERT_CTL_RATE_HI:`BERT_CTL_RATE_LO];
         end
         if (wr && paddr_i == `BERT_CFG_OFS)
            pattern_cfg <= pwdata_i & 32'h0003_1f1f;
         if (wr && paddr_i == `BERT_SEED_OFS)
            seed <= pwdata_i;
         if (wr && paddr_i == `BERT_IEN_OFS)
            tester_event_enables <= pwdata_i[3:0];
         if (wr && paddr_i == `BERT_GIC_OFS)
            clear_by_write_select <= pwdata_i[`BERT_GIC_CWE];
         // update flag holds until the bit count snapshot is read; a new update wins
         if (pmu_go)
            perf_update_status <= 1'b1;
         else if (rd && paddr_i == `BERT_BITCNT_OFS)
            perf_update_status <= 1'b0;
      end
   end

   // read mux
   always @* begin
      rdata = 32'h0000_0000;
      rd_ok = 1'b1;
      case (paddr_i)
         `BERT_TOP_CTL_OFS: rdata = {31'd0, tester_enable};
         `BERT_CTL_OFS:     rdata = {21'd0, err_rate, 1'b0, auto_resync_dis,
                                     tx_invert, err_src_pin, 1'b0,
                                     perf_update_trigger, rx_pattern_load,
                                     tx_pattern_load};
         `BERT_CFG_OFS:     rdata = pattern_cfg;
         `BERT_SEED_OFS:    rdata = seed;
         `BERT_LIVE_OFS:    rdata = {28'd0, oos_now, nz_now, 1'b0,
                                     perf_update_status};
         `BERT_LAT_OFS:     rdata = {28'd0, tester_latched_events};
         `BERT_IEN_OFS:     rdata = {28'd0, tester_event_enables};
         `BERT_GIC_OFS:     rdata = {31'd0, clear_by_write_select};
         `BERT_BITCNT_OFS:  rdata = bit_count_rd;
         `BERT_ERRCNT_OFS:  rdata = {8'd0, error_count_rd};
         default:           rd_ok = 1'b0;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i & penable_i & ~pready_o;
         if (psel_i && penable_i && !pready_o) begin
            prdata_o  <= pwrite_i ? 32'h0000_0000 : rdata;
            pslverr_o <= ~rd_ok;
         end else begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
         end
      end
   end
endmodule // bert_top

// *** tb/bert_chan.sv ***
// channel model: asks for transmit bits and loops them back to the receiver
`timescale 1ns/100ps
module bert_chan (
   input  wire clk_i,
   input  wire run_i,
   input  wire slow_i,
   input  wire tx_data_i,
   input  wire tx_valid_i,
   output reg  tx_bit_req_o = 1'b0,
   output reg  rx_data_o = 1'b0,
   output reg  rx_valid_o = 1'b0
);
   reg [1:0] gap = 2'h0;
   // slow mode spaces payload slots three cycles apart
   always @(posedge clk_i) begin
      gap <= (gap == 2'h2) ? 2'h0 : gap + 2'h1;
      tx_bit_req_o <= run_i && (!slow_i || gap == 2'h0);
      rx_valid_o <= tx_valid_i;
      // idle slots toggle so a stale bit is never taken for payload
      rx_data_o <= tx_valid_i ? tx_data_i : !rx_data_o;
   end
endmodule // bert_chan

// *** tb/bert_props.sv ***
// assertions on the ports of the bit error rate tester
`timescale 1ns/100ps
module bert_props (
   input wire        clk_i,
   input wire        rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        tx_bit_req_i,
   input wire        tx_data_o,
   input wire        tx_valid_o,
   input wire        rx_valid_i,
   input wire        out_of_sync_o,
   input wire        irq_n_o
);
   reg [3:0] ien;
   reg [3:0] ien_d;
   // shadow of the enable register, two stages so the registered irq has settled
   always @(posedge clk_i) begin
      if (rst_i) begin
         ien   <= 4'h0;
         ien_d <= 4'h0;
      end else begin
         if (psel_i && penable_i && pready_o && pwrite_i && paddr_i == 8'h18)
            ien <= pwdata_i[3:0];
         ien_d <= ien;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ready_second: assert property ($rose(penable_i) && psel_i |-> !pready_o ##1 pready_o)
      else $error("pready not in second access cycle");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr_o |-> pready_o && psel_i && penable_i)
      else $error("pslverr outside a transfer answer");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside answer cycle");
   a_tx_answer: assert property (tx_valid_o |-> $past(tx_bit_req_i))
      else $error("tx bit without a request");
   a_tx_hold: assert property (!tx_valid_o |-> $stable(tx_data_o))
      else $error("tx data moved without a new bit");
   a_irq_masked: assert property (ien == 4'h0 && ien_d == 4'h0 |-> irq_n_o)
      else $error("irq low with all events masked");
   a_sync_gain: assert property ($fell(out_of_sync_o) |-> $past(rx_valid_i) || $past(rx_valid_i, 2))
      else $error("sync gained without a received bit");
endmodule // bert_props

bind bert_top bert_props u_props (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .tx_bit_req_i(tx_bit_req_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
   .rx_valid_i(rx_valid_i), .out_of_sync_o(out_of_sync_o), .irq_n_o(irq_n_o));

// *** tb/bert_top_test.sv ***
// self-checking bench for the bit error rate tester
`timescale 1ns/100ps
module bert_top_test;
   reg          clk_i = 1'b0;
   reg          rst_i = 1'b1;
   reg          psel_i = 1'b0;
   reg          penable_i = 1'b0;
   reg          pwrite_i = 1'b0;
   reg  [7:0]   paddr_i = 8'h00;
   reg  [31:0]  pwdata_i = 32'h0;
   reg          pin = 1'b0;
   reg          run = 1'b0;
   reg          slow = 1'b0;
   wire [31:0]  prdata_o;
   wire         pready_o, pslverr_o, req, tx_d, tx_v, rx_d, rx_v, out_of_sync, irq_n;
   int          bad_count = 0;
   int          n_tests = 0;
   logic        serr;
   logic [31:0] q;
   logic [31:0] ctl = 32'h0;
   always #25 clk_i = ~clk_i;
   bert_top dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_bit_req_i(req), .tx_data_o(tx_d),
      .tx_valid_o(tx_v), .rx_data_i(rx_d), .rx_valid_i(rx_v),
      .manual_error_insert_in_i(pin), .out_of_sync_o(out_of_sync), .irq_n_o(irq_n));
   bert_chan chan (.clk_i(clk_i), .run_i(run), .slow_i(slow), .tx_data_i(tx_d),
      .tx_valid_i(tx_v), .tx_bit_req_o(req), .rx_data_o(rx_d), .rx_valid_o(rx_v));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      // no local limit: only the watchdog may end a stuck transfer
      do @(posedge clk_i); while (pready_o !== 1'b1);
      q = prdata_o;
      serr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic set_ctl(input logic [31:0] v);
      ctl = v;
      apb(1'b1, 8'h04, v);
   endtask
   // loads act on a rising control bit, so write it low first
   task automatic pulse(input logic [31:0] m);
      set_ctl(ctl & ~m);
      set_ctl(ctl | m);
   endtask
   task automatic wait_for(input logic is_irq, input logic v, input int lim);
      int n;
      n = 0;
      while ((is_irq ? irq_n : out_of_sync) !== v && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk(is_irq ? "irq_n" : "out_of_sync", v, is_irq ? irq_n : out_of_sync);
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic t_regs();
      logic [7:0] ofs [5] = '{8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c};
      foreach (ofs[i]) begin
         apb(1'b0, ofs[i], 32'h0);
         chk("reset_value", 32'h0, q);
      end
      apb(1'b0, 8'h10, 32'h0);
      chk("live_oos", 32'h8, q & 32'h8);
      apb(1'b1, 8'h40, 32'hffff_ffff);
      chk("wr_refused", 1'b1, serr);
      apb(1'b0, 8'h40, 32'h0);
      chk("rd_refused", 32'h1, q | serr);
   endtask
   task automatic t_pattern(input logic [31:0] cfg, input logic [31:0] seed, input logic inv);
      logic [31:0] s;
      logic        b;
      logic        f;
      logic        o;
      int          n;
      int          y;
      n = cfg[4:0] + 1;
      y = cfg[12:8] + 1;
      s = seed & (32'hffff_ffff >> (32 - n));
      run <= 1'b0;
      set_ctl(inv ? (ctl | 32'h20) : (ctl & ~32'h20));
      apb(1'b1, 8'h08, cfg);
      apb(1'b1, 8'h0c, seed);
      pulse(32'h3);
      run <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         f = cfg[16] ? s[n-1] : s[n-1] ^ s[y-1];
         if (cfg[17]) f = s[16] ^ s[19];
         if (!cfg[16] && s[30:0] == 31'h0) f = 1'b1;
         // qrss caps zero runs at the output only; the register keeps the feedback
         o = f | (cfg[17] && s[13:0] == 14'h0);
         s = {s[30:0], f};
         do @(posedge clk_i); while (tx_v !== 1'b1);
         b = tx_d;
         chk("tx_bit", o ^ inv, b);
      end
      if (!inv) wait_for(1'b0, 1'b0, 400);
   endtask
   task automatic t_count();
      logic [31:0] b;
      pulse(32'h4);
      apb(1'b1, 8'h04, ctl | 32'h8);
      repeat (60) @(posedge clk_i);
      apb(1'b0, 8'h10, 32'h0);
      chk("live_errs", 32'h5, q & 32'hd);
      pulse(32'h4);
      apb(1'b0, 8'h24, 32'h0);
      chk("err_count", 32'h1, q);
      apb(1'b0, 8'h20, 32'h0);
      b = q;
      chk("bit_count", 1'b1, b > 50 && b < 100);
      apb(1'b0, 8'h14, 32'h0);
      chk("latched", 32'h3, q & 32'h3);
   endtask
   task automatic t_irq();
      apb(1'b1, 8'h1c, 32'h1);
      apb(1'b1, 8'h14, 32'hf);
      apb(1'b1, 8'h18, 32'h2);
      set_ctl(ctl | 32'h10);
      pin <= 1'b1;
      @(posedge clk_i);
      pin <= 1'b0;
      wait_for(1'b1, 1'b0, 100);
      apb(1'b0, 8'h14, 32'h0);
      chk("lat_bit_err", 32'h2, q & 32'h2);
      repeat (2) @(posedge clk_i);
      chk("irq_held", 1'b0, irq_n);
      apb(1'b1, 8'h14, 32'h2);
      wait_for(1'b1, 1'b1, 4);
      apb(1'b1, 8'h1c, 32'h0);
      set_ctl(ctl & ~32'h10);
      apb(1'b1, 8'h04, ctl | 32'h8);
      wait_for(1'b1, 1'b0, 100);
      apb(1'b0, 8'h14, 32'h0);
      wait_for(1'b1, 1'b1, 4);
      apb(1'b1, 8'h18, 32'h0);
   endtask
   task automatic t_resync();
      logic [31:0] b;
      set_ctl(ctl | 32'h140);
      pulse(32'h4);
      repeat (200) @(posedge clk_i);
      pulse(32'h4);
      chk("sync_held", 1'b0, out_of_sync);
      apb(1'b0, 8'h20, 32'h0);
      b = q;
      apb(1'b0, 8'h24, 32'h0);
      chk("rate_errs", 1'b1, q * 10 + 12 > b && q * 10 < b + 12);
      set_ctl(ctl & ~32'h40);
      wait_for(1'b0, 1'b1, 300);
      set_ctl(ctl & ~32'h700);
      wait_for(1'b0, 1'b0, 600);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      $display("registers done");
      apb(1'b1, 8'h00, 32'h1);
      slow <= 1'b1;
      t_pattern(32'h0001_0007, 32'h0000_00a5, 1'b0);
      slow <= 1'b0;
      t_pattern(32'h0000_0506, 32'h0, 1'b1);
      t_pattern(32'h0002_0013, 32'h1, 1'b1);
      t_pattern(32'h0000_0506, 32'h1, 1'b0);
      $display("patterns done");
      t_count();
      $display("counters done");
      t_irq();
      $display("interrupts done");
      t_resync();
      $display("resync done");
      results();
   end
   initial begin
      #(50 * 30000);
      bad_count++;
      results();
   end
endmodule // bert_top_test
